// ==== include/bppm_map.svh ====
// Register offsets, field positions and reset values of the port pin mux
`ifndef BPPM_MAP_SVH
`define BPPM_MAP_SVH
`define BPPM_OFF_DIR_D     12'h000
`define BPPM_OFF_LAT_D     12'h004
`define BPPM_OFF_PIN_D     12'h008
`define BPPM_OFF_ANS_D     12'h00C
`define BPPM_OFF_DIR_C     12'h010
`define BPPM_OFF_LAT_C     12'h014
`define BPPM_OFF_PIN_C     12'h018
`define BPPM_OFF_ANS_C     12'h01C
`define BPPM_OFF_SLEW      12'h020
`define BPPM_OFF_PERIPH    12'h024
`define BPPM_OFF_CFG       12'h028
`define BPPM_RST_DIR       8'hFF
`define BPPM_RST_LAT       8'h00
`define BPPM_RST_ANS       8'hFF
`define BPPM_RST_ANS_C     8'hFC
`define BPPM_ANS_C_MASK    8'hFC
`define BPPM_RST_SLEW      8'h1F
`define BPPM_SLEW_MASK     8'h1F
`define BPPM_RST_CFG       8'h03
`define BPPM_CFG_PWM2_BIT  0
`define BPPM_CFG_CAP3_BIT  1
`endif

// ==== include/bppm_pkg.sv ====
// Types shared by the port pin mux
package bppm_pkg;
   typedef struct packed {
      logic [7:0] dir_d;
      logic [7:0] lat_d;
      logic [7:0] ans_d;
      logic [7:0] dir_c;
      logic [7:0] lat_c;
      logic [7:0] ans_c;
      logic [7:0] slew;
      logic [7:0] cfg;
      logic [7:0] pin_d_smp;
      logic [7:0] pin_c_smp;
      logic       dph_act;
      logic       dph_wr;
      logic [11:0] dph_addr;
      logic [31:0] rdata;
      logic [7:0] pad_d_out;
      logic [7:0] pad_d_oe_n;
      logic [7:0] pad_c_out;
      logic [7:0] pad_c_oe_n;
      logic [7:0] ana_en_d;
      logic [2:0] ana_en_c;
      logic [15:0] periph_in;
   } bppm_state_t;

   // Peripheral output requests: enable and value per function
   typedef struct packed {
      logic en;
      logic val;
   } bppm_req_t;

   typedef struct packed {
      bppm_req_t serial2_clock;    // also two-wire clock
      bppm_req_t twowire2_data;
      bppm_req_t serial2_data_out;
      bppm_req_t capture4_out;
      bppm_req_t pwm2_out2;
      bppm_req_t pwm2_out4;
      bppm_req_t pwm2_out3;
      bppm_req_t pwm1_out2;
      bppm_req_t pwm1_out3;
      bppm_req_t pwm1_out4;
      bppm_req_t xcvr2_tx_clk;
      bppm_req_t xcvr2_data;
      bppm_req_t serial1_data_out;
      bppm_req_t pwm3_out1;        // also capture unit three compare
      bppm_req_t pwm3_out2;
      bppm_req_t xcvr1_tx_clk;
      bppm_req_t xcvr1_data;
   } bppm_periph_out_t;
endpackage

// ==== src/bppm_port.sv ====
// Eight-bit bidirectional port with upper third-port pins, AHB-Lite registers and pin mux
//
// How it works
// (R1) Eight port pins, each direction set by its own direction bit.
// (R2) Direction bit 1 turns the driver off; pin is an input.
// (R3) Direction bit 0 drives the output latch value onto the pin.
// (R4) Latch is its own register; reads return latch, not pin level.
// (R5) After reset all pins are analog inputs.
// (R6) Several enabled output functions: highest priority function takes the pin.
// (R7) Analog input paths are enabled only while analog-select is set.
// (R8) Peripheral outputs still drive pins that are in analog mode.
// (R9) Analog-select 1 disables the pin's digital input path.
// (R10) Latch drive with direction 0 works whatever analog-select says.
// (R11) Port pins 0-7 feed channels 20-27; third port 5-7 feed 17-19.
// (R12) Serial port two: pin0 clock, pin1 data in, pin3 select, pin4 data out.
// (R13) Two-wire mode: pin0 clock in/out, pin1 data in/out.
// (R14) Transceiver two: pin6 transmit or clock, pin7 receive or data.
// (R15) PWM one outputs 2,3,4 on pins 5,6,7 with direction 0.
// (R16) PWM two output 2 on pin2, output 4 on pin3, output 3 on pin4.
// (R17) Capture unit four on pin1: output with direction 0, capture input otherwise.
// (R18) Third port: pin5 serial one data out, pins 6,7 transceiver one.
// (R19) Relocation bits set keep PWM two output 2 and capture three on defaults.
// (R20) Capture three relocation clear moves it to third port pins 6 and 7.
// (R21) Unimplemented register bits read as zero.
// (R22) Analog-select pins read 0 on digital reads of the port register.
// (R23) Port write updates latch; port read returns sampled enabled digital inputs.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`include "bppm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module bppm_port (
   input  wire logic                       hclk,        // Bus clock, 20 MHz
   input  wire logic                       hresetn,     // Asynchronous reset, active low
   input  wire logic                       hsel,        // Slave select
   input  wire logic [11:0]                haddr,       // Byte address
   input  wire logic [1:0]                 htrans,      // Transfer type
   input  wire logic                       hwrite,      // Write when high
   input  wire logic [2:0]                 hsize,       // Transfer size
   input  wire logic                       hready,      // Bus ready
   input  wire logic [31:0]                hwdata,      // Write data
   output var  logic [31:0]                hrdata,      // Read data
   output var  logic                       hreadyout,   // Always ready
   output var  logic                       hresp,       // Always OKAY
   input  wire logic [7:0]                 pad_d_in,    // Port pin levels
   output var  logic [7:0]                 pad_d_out,   // Port pin drive values
   output var  logic [7:0]                 pad_d_oe_n,  // Port drive enables, low drives
   input  wire logic [2:0]                 pad_c_in,    // Third-port pins 5..7 levels
   output var  logic [2:0]                 pad_c_out,   // Third-port pins 5..7 drive values
   output var  logic [2:0]                 pad_c_oe_n,  // Third-port drive enables, low drives
   input  wire bppm_pkg::bppm_periph_out_t periph_out,  // Peripheral output requests
   output var  logic [15:0]                periph_in,   // Digital inputs to peripherals
   output var  logic [7:0]                 ana_en_d,    // Channel 20..27 analog enables
   output var  logic [2:0]                 ana_en_c,    // Channel 17..19 analog enables
   output var  logic [7:0]                 slew_control // Slew control bits
);
   bppm_pkg::bppm_state_t st;
   bppm_pkg::bppm_state_t next_st;
   logic       req;
   logic [7:0] wb;
   logic [7:0] dig_d;
   logic [7:0] dig_c;
   logic [7:0] rd_byte;
   logic [7:0] drv_d;
   logic [7:0] val_d;
   logic [7:0] drv_c;
   logic [7:0] val_c;

   // ---------------------------------------------------------------
   // Bus access
   // ---------------------------------------------------------------
   assign req = hsel & hready & htrans[1];
   assign wb  = hwdata[7:0];

   // ---------------------------------------------------------------
   // Pin mux, highest priority first, latch last
   // ---------------------------------------------------------------
   always_comb begin
      drv_d = ~st.dir_d;                                            // [R1] [R2] [R3] [R10]
      val_d = st.lat_d;                                             // [R3] [R8]
      drv_c = ~st.dir_c;
      val_c = st.lat_c;
      // Pin 0: serial clock or two-wire clock
      if (periph_out.serial2_clock.en) begin                        // [R12] [R13]
         drv_d[0] = 1'b1;
         val_d[0] = periph_out.serial2_clock.val;
      end
      // Pin 1: capture four output over two-wire data
      if (periph_out.capture4_out.en && !st.dir_d[1]) begin         // [R17] [R6]
         drv_d[1] = 1'b1;
         val_d[1] = periph_out.capture4_out.val;
      end else if (periph_out.twowire2_data.en) begin               // [R13]
         drv_d[1] = 1'b1;
         val_d[1] = periph_out.twowire2_data.val;
      end
      // Pin 2: PWM two output 2 only on its default pin
      if (periph_out.pwm2_out2.en && st.cfg[`BPPM_CFG_PWM2_BIT] &&
          !st.dir_d[2]) begin                                       // [R19] [R16]
         drv_d[2] = 1'b1;
         val_d[2] = periph_out.pwm2_out2.val;
      end
      if (periph_out.pwm2_out4.en && !st.dir_d[3]) begin            // [R16]
         drv_d[3] = 1'b1;
         val_d[3] = periph_out.pwm2_out4.val;
      end
      if (periph_out.pwm2_out3.en && !st.dir_d[4]) begin            // [R16] [R6]
         drv_d[4] = 1'b1;
         val_d[4] = periph_out.pwm2_out3.val;
      end else if (periph_out.serial2_data_out.en) begin            // [R12]
         drv_d[4] = 1'b1;
         val_d[4] = periph_out.serial2_data_out.val;
      end
      if (periph_out.pwm1_out2.en && !st.dir_d[5]) begin            // [R15]
         drv_d[5] = 1'b1;
         val_d[5] = periph_out.pwm1_out2.val;
      end
      if (periph_out.pwm1_out3.en && !st.dir_d[6]) begin            // [R15] [R6]
         drv_d[6] = 1'b1;
         val_d[6] = periph_out.pwm1_out3.val;
      end else if (periph_out.xcvr2_tx_clk.en) begin                // [R14]
         drv_d[6] = 1'b1;
         val_d[6] = periph_out.xcvr2_tx_clk.val;
      end
      if (periph_out.pwm1_out4.en && !st.dir_d[7]) begin            // [R15] [R6]
         drv_d[7] = 1'b1;
         val_d[7] = periph_out.pwm1_out4.val;
      end else if (periph_out.xcvr2_data.en) begin                  // [R14]
         drv_d[7] = 1'b1;
         val_d[7] = periph_out.xcvr2_data.val;
      end
      // Third port pins 5..7
      if (periph_out.serial1_data_out.en && !st.dir_c[5]) begin     // [R18]
         drv_c[5] = 1'b1;
         val_c[5] = periph_out.serial1_data_out.val;
      end
      // Capture three moves here only when its relocation bit is clear
      if (periph_out.pwm3_out1.en && !st.cfg[`BPPM_CFG_CAP3_BIT] &&
          !st.dir_c[6]) begin                                       // [R20] [R6]
         drv_c[6] = 1'b1;
         val_c[6] = periph_out.pwm3_out1.val;
      end else if (periph_out.xcvr1_tx_clk.en) begin                // [R18]
         drv_c[6] = 1'b1;
         val_c[6] = periph_out.xcvr1_tx_clk.val;
      end
      if (periph_out.pwm3_out2.en && !st.cfg[`BPPM_CFG_CAP3_BIT] &&
          !st.dir_c[7]) begin                                       // [R20] [R6]
         drv_c[7] = 1'b1;
         val_c[7] = periph_out.pwm3_out2.val;
      end else if (periph_out.xcvr1_data.en) begin                  // [R18]
         drv_c[7] = 1'b1;
         val_c[7] = periph_out.xcvr1_data.val;
      end
   end

   // ---------------------------------------------------------------
   // Digital input path to the peripheral inputs
   // ---------------------------------------------------------------
   always_comb begin
      dig_d = st.pin_d_smp & ~st.ans_d;                             // [R9] [R22]
      dig_c = {st.pin_c_smp[7:5] & ~st.ans_c[7:5], 5'h0_0};         // [R9] [R22]
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.pin_d_smp = pad_d_in;
      next_st.pin_c_smp = {pad_c_in, 5'h0_0};
      next_st.dph_act = req;
      if (req) begin
         next_st.dph_wr   = hwrite;
         next_st.dph_addr = {haddr[11:2], 2'b00};
      end
      if (st.dph_act && st.dph_wr) begin
         case (st.dph_addr)
            `BPPM_OFF_DIR_D: next_st.dir_d = wb;                    // [R1]
            `BPPM_OFF_LAT_D: next_st.lat_d = wb;                    // [R4]
            `BPPM_OFF_PIN_D: next_st.lat_d = wb;                    // [R23]
            `BPPM_OFF_ANS_D: next_st.ans_d = wb;
            `BPPM_OFF_DIR_C: next_st.dir_c = wb;
            `BPPM_OFF_LAT_C: next_st.lat_c = wb;
            `BPPM_OFF_PIN_C: next_st.lat_c = wb;
            `BPPM_OFF_ANS_C: next_st.ans_c = wb & `BPPM_ANS_C_MASK;
            `BPPM_OFF_SLEW:  next_st.slew = wb & `BPPM_SLEW_MASK;
            `BPPM_OFF_CFG:   next_st.cfg = wb & `BPPM_RST_CFG;      // [R19] [R20]
            default:         next_st.slew = st.slew;
         endcase
      end
      // Read byte is fetched in the address phase so it stands in the data phase;
      // it looks at the values this edge stores, so a read right behind a write
      // returns the freshly written byte
      case ({haddr[11:2], 2'b00})
         `BPPM_OFF_DIR_D:  rd_byte = next_st.dir_d;
         `BPPM_OFF_LAT_D:  rd_byte = next_st.lat_d;                 // [R4]
         `BPPM_OFF_PIN_D:  rd_byte = st.pin_d_smp & ~next_st.ans_d; // [R22] [R23]
         `BPPM_OFF_ANS_D:  rd_byte = next_st.ans_d;
         `BPPM_OFF_DIR_C:  rd_byte = next_st.dir_c;
         `BPPM_OFF_LAT_C:  rd_byte = next_st.lat_c;                 // [R4]
         `BPPM_OFF_PIN_C:  rd_byte = {st.pin_c_smp[7:5] & ~next_st.ans_c[7:5], 5'h0_0};
         `BPPM_OFF_ANS_C:  rd_byte = next_st.ans_c & `BPPM_ANS_C_MASK; // [R21]
         `BPPM_OFF_SLEW:   rd_byte = next_st.slew & `BPPM_SLEW_MASK;   // [R21]
         `BPPM_OFF_PERIPH: rd_byte = drv_d;
         `BPPM_OFF_CFG:    rd_byte = next_st.cfg & `BPPM_RST_CFG;      // [R21]
         default:          rd_byte = 8'h00;
      endcase
      next_st.rdata      = (req && !hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      next_st.pad_d_out  = val_d;
      next_st.pad_d_oe_n = ~drv_d;                                  // [R2] [R3]
      next_st.pad_c_out  = val_c;
      next_st.pad_c_oe_n = ~drv_c;
      next_st.ana_en_d   = st.ans_d;                                // [R7] [R11]
      next_st.ana_en_c   = st.ans_c[7:5];                           // [R7] [R11]
      // Peripheral inputs: d0 clk, d1 data/capture4, d3 select, d6/d7 xcvr2, c6/c7 xcvr1
      next_st.periph_in  = {dig_c[7:5], 5'h0_0, dig_d};             // [R12] [R14] [R17]
   end

   // ---------------------------------------------------------------
   // State register; reset leaves every pin an analog input
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st            <= '0;
         st.dir_d      <= `BPPM_RST_DIR;                            // [R5]
         st.dir_c      <= `BPPM_RST_DIR;                            // [R5]
         st.ans_d      <= `BPPM_RST_ANS;                            // [R5]
         st.ans_c      <= `BPPM_RST_ANS_C;                          // [R5]
         st.slew       <= `BPPM_RST_SLEW;
         st.cfg        <= `BPPM_RST_CFG;
         st.pad_d_oe_n <= 8'hFF;
         st.pad_c_oe_n <= 8'hFF;
         st.ana_en_d   <= `BPPM_RST_ANS;
         st.ana_en_c   <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   assign hrdata       = st.rdata;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign pad_d_out    = st.pad_d_out;
   assign pad_d_oe_n   = st.pad_d_oe_n;
   assign pad_c_out    = st.pad_c_out[7:5];
   assign pad_c_oe_n   = st.pad_c_oe_n[7:5];
   assign periph_in    = st.periph_in;
   assign ana_en_d     = st.ana_en_d;
   assign ana_en_c     = st.ana_en_c;
   assign slew_control = st.slew;
endmodule
`default_nettype wire

// ==== test/bppm_port_properties.sv ====
// Concurrent checks on the port pin mux, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module bppm_port_props (
   input wire logic                       hclk,       // Clock
   input wire logic                       hresetn,    // Reset, active low
   input wire logic                       hsel,       // Select
   input wire logic [1:0]                 htrans,     // Transfer type
   input wire logic                       hwrite,     // Write
   input wire logic                       hready,     // Bus ready
   input wire logic [31:0]                hrdata,     // Read data
   input wire logic [7:0]                 pad_d_out,  // Port drive
   input wire logic [7:0]                 pad_d_oe_n, // Port enables
   input wire logic [2:0]                 pad_c_out,  // Third-port drive
   input wire logic [2:0]                 pad_c_oe_n, // Third-port enables
   input wire bppm_pkg::bppm_periph_out_t periph_out, // Requests
   input wire logic [15:0]                periph_in,  // Digital inputs
   input wire logic [7:0]                 ana_en_d,   // Analog enables
   input wire logic [2:0]                 ana_en_c    // Analog enables
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_dph;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_dph <= 1'b0;
      end else begin
         rd_dph <= hsel & hready & htrans[1] & ~hwrite;
      end
   end
   reset_state_a: assert property ($rose(hresetn) |-> pad_d_oe_n == 8'hff &&
      pad_c_oe_n == 3'h7 && ana_en_d == 8'hff && ana_en_c == 3'h7 && periph_in == 16'h0000)
      else $error("pins not analog inputs after reset");
   upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
      else $error("unimplemented read bits not zero");
   idle_rdata_a: assert property (!rd_dph |-> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");
   dig_gate_d_a: assert property (ana_en_d == $past(ana_en_d) &&
      ana_en_d == $past(ana_en_d, 2) |-> (periph_in[7:0] & ana_en_d) == 8'h00)
      else $error("analog port pin seen as digital input");
   dig_gate_c_a: assert property (ana_en_c == $past(ana_en_c) &&
      ana_en_c == $past(ana_en_c, 2) |-> (periph_in[15:13] & ana_en_c) == 3'h0)
      else $error("analog third-port pin seen as digital input");
   sclk_override_a: assert property ($past(hresetn && periph_out.serial2_clock.en) |->
      !pad_d_oe_n[0] && pad_d_out[0] == $past(periph_out.serial2_clock.val))
      else $error("serial clock not on pin 0");
   pwm1_pin5_a: assert property ($past(hresetn && periph_out.pwm1_out2.en) &&
      !pad_d_oe_n[5] |-> pad_d_out[5] == $past(periph_out.pwm1_out2.val))
      else $error("pwm output 2 not on pin 5");
   serial1_data_out_pin_a: assert property ($past(hresetn && periph_out.serial1_data_out.en) &&
      !pad_c_oe_n[0] |-> pad_c_out[0] == $past(periph_out.serial1_data_out.val))
      else $error("serial one data not on third-port pin 5");
   xcvr2_data_a: assert property ($past(hresetn && periph_out.xcvr2_data.en &&
      !periph_out.pwm1_out4.en) |-> !pad_d_oe_n[7] &&
      pad_d_out[7] == $past(periph_out.xcvr2_data.val))
      else $error("transceiver data not on pin 7");
endmodule
bind bppm_port bppm_port_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .pad_d_out(pad_d_out),
   .pad_d_oe_n(pad_d_oe_n), .pad_c_out(pad_c_out), .pad_c_oe_n(pad_c_oe_n),
   .periph_out(periph_out), .periph_in(periph_in), .ana_en_d(ana_en_d), .ana_en_c(ana_en_c));
`default_nettype wire

// ==== test/bppm_pad_model.sv ====
// Board-side model of the port pins
`timescale 1ns/1ps
`default_nettype none
module bppm_pad_model (
   input  wire logic        hclk,    // Clock that ages floating pins
   input  wire logic [10:0] oe_n,    // Device enables, low drives
   input  wire logic [10:0] dev_out, // Device drive values
   input  wire logic [10:0] ext_val, // Board levels
   input  wire logic [10:0] ext_en,  // Board drives where high
   output var  logic [10:0] lvl      // Resolved pin levels
);
   logic [10:0] last_lvl = 11'h000;
   // No pull here: an undriven pin flips every cycle so it never looks settled
   assign lvl = (~oe_n & dev_out) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & ~last_lvl);
   always_ff @(posedge hclk) begin
      last_lvl <= lvl;
   end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the port pin mux
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                       hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [11:0]                haddr;
   logic [1:0]                 htrans;
   logic [2:0]                 hsize, pad_c_in, pad_c_out, pad_c_oe_n, ana_en_c;
   logic [31:0]                hwdata, hrdata, r;
   logic [7:0]                 pad_d_in, pad_d_out, pad_d_oe_n, ana_en_d, slew_control;
   logic [15:0]                periph_in;
   logic [10:0]                ext_val, ext_en, lvl, oe11, out11;
   bppm_pkg::bppm_periph_out_t periph_out;
   int                         fails, total_checks, dd, dc, p, v, m[12];
   int                         seed = 32'he044_765b;
   int                         pin_of[17] = '{0, 1, 4, 1, 2, 3, 4, 5, 6, 7, 6, 7, 8, 9, 10, 9, 10};
   int                         hi[6] = '{3, 6, 8, 9, 13, 14};
   int                         lo[6] = '{1, 2, 10, 11, 15, 16};
   localparam logic [16:0]     OVR = 17'h1_8c07;
   assign oe11 = {pad_c_oe_n, pad_d_oe_n};
   assign out11 = {pad_c_out, pad_d_out};
   assign pad_d_in = lvl[7:0];
   assign pad_c_in = lvl[10:8];
   bppm_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pad_d_in(pad_d_in), .pad_d_out(pad_d_out),
      .pad_d_oe_n(pad_d_oe_n), .pad_c_in(pad_c_in), .pad_c_out(pad_c_out),
      .pad_c_oe_n(pad_c_oe_n), .periph_out(periph_out), .periph_in(periph_in),
      .ana_en_d(ana_en_d), .ana_en_c(ana_en_c), .slew_control(slew_control));
   bppm_pad_model board (.hclk(hclk), .oe_n(oe11), .dev_out(out11), .ext_val(ext_val),
      .ext_en(ext_en), .lvl(lvl));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic wr, input int idx, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= 12'(idx * 4);
      // Address phase ends at the first edge that sees ready high
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'($random(seed)), d};
      // Read data is taken at the edge that ends the data phase
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input int idx, input int x);
      bus(1'b1, idx, 8'(x));
      if (idx == 2 || idx == 6) m[idx - 1] = x & 8'hff;
      else if (idx != 9 && idx < 11) m[idx] = x & (idx == 7 ? 8'hfc : idx == 8 ? 8'h1f :
         idx == 10 ? 8'h03 : 8'hff);
   endtask
   task automatic rd(input int idx, input int exp);
      bus(1'b0, idx, 8'h00);
      chk($sformatf("reg %0d", idx), exp, r);
   endtask
   task automatic settle;
      repeat (4) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic pads;
      dd = ((~m[0] & m[1]) | (m[0] & ext_val[7:0])) & ~m[3] & 8'hff;
      dc = (((~m[4] & m[5]) | (m[4] & {ext_val[10:8], 5'h00})) & ~m[7]) >> 5 & 7;
      settle;
      chk("oe_d", m[0] & 8'hff, pad_d_oe_n);
      chk("out_d", m[1] & ~m[0] & 8'hff, pad_d_out & ~pad_d_oe_n);
      chk("oe_c", m[4] >> 5 & 7, pad_c_oe_n);
      chk("out_c", m[5] >> 5 & ~(m[4] >> 5) & 7, pad_c_out & ~pad_c_oe_n);
      chk("ana", (m[7] >> 5 & 7) << 8 | m[3] & 8'hff, {ana_en_c, ana_en_d});
      chk("pin_in", dc << 13 | dd, periph_in);
      chk("slew", m[8], slew_control);
   endtask
   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      m = '{8'hff, 0, 0, 8'hff, 8'hff, 0, 0, 8'hfc, 8'h1f, 0, 8'h03, 0};
      pads;
      for (int i = 0; i < 12; i++) if (i != 2 && i != 6 && i != 9) rd(i, m[i]);
      $display("reset test done");
   endtask
   initial begin
      {hsel, hwrite, haddr, htrans, hwdata, ext_val, fails, total_checks} = '0;
      hresetn = 1'b0;
      hsize = 3'b010;
      periph_out = '0;
      ext_en = 11'h7ff;
      do_reset;
      for (int it = 0; it < 8; it++) begin
         ext_val <= 11'($random(seed));
         // Odd passes load the latches through the pin value registers
         for (int i = 0; i < 12; i++) begin
            if (i != 2 && i != 6) wr(i + (it % 2 == 1 && (i == 1 || i == 5) ? 1 : 0),
               $random(seed));
         end
         pads;
         rd(2, dd);
         bus(1'b0, 6, 8'h00);
         chk("pin_c", dc << 5, r & 32'h0000_00e0);
         rd(9, ~m[0] & 8'hff);
         for (int i = 0; i < 12; i++) if (i != 2 && i != 6 && i != 9) rd(i, m[i]);
      end
      $display("register test done");
      wr(10, 1);
      wr(3, 8'hff);
      wr(7, 8'hff);
      for (int d = 0; d < 2; d++) begin
         wr(0, d ? 8'hff : 0);
         wr(4, d ? 8'hff : 0);
         for (int k = 0; k < 17; k++) begin
            p = pin_of[k];
            v = ((((m[5] >> 5 & 7) << 8 | m[1] & 8'hff) >> p) & 1) ^ 1;
            @(posedge hclk);
            periph_out <= 34'(2 | v) << (32 - 2 * k);
            settle;
            chk("mux_oe", (d == 0 || OVR[k]) ? 0 : 1, oe11[p]);
            if (d == 0 || OVR[k]) chk("mux_val", v, out11[p]);
         end
      end
      $display("mux test done");
      wr(0, 0);
      wr(4, 0);
      for (int j = 0; j < 6; j++) begin
         @(posedge hclk);
         periph_out <= (34'(3) << (32 - 2 * hi[j])) | (34'(2) << (32 - 2 * lo[j]));
         settle;
         chk("prio", 1, out11[pin_of[hi[j]]]);
      end
      @(posedge hclk);
      periph_out <= '0;
      $display("priority test done");
      do_reset;
      summarize;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      fails++;
      $display("[ERR] watchdog expected done seen hang");
      summarize;
   end
endmodule
`default_nettype wire
